// file: src/sof_map.svh
// constants, encodings and behaviour notes for the store ordering and flush block
// Notes on behaviour
// - mode bit set selects partial ordering, else total
// - partial ordering optional; total alone conforms
// - fenced programs behave alike in both modes
// - stores, flushes, atomics take memory one at a time
// - store barrier keeps surrounding stores in order
// - same doubleword stores stay in issue order
// - io loads and stores stay in program order
// - loads see latest store, own included
// - load completes before any later operation issues
// - atomic load before store, nothing between; io atomics take no lock, so another master may come between
// - every store and atomic eventually completes
// - flush orders fetches with own loads, stores
// - own fetch sees store five instructions after flush
// - store then flush reaches every fetch path
// - own instruction fetches stay in issue order
// - flush exposes earlier stores from any processor
`ifndef SOF_MAP_SVH
`define SOF_MAP_SVH
`define SOF_OP_LOAD 3'h0
`define SOF_OP_STORE 3'h1
`define SOF_OP_FLUSH 3'h2
`define SOF_OP_ATOMIC 3'h3
`define SOF_OP_BARRIER 3'h4
`define SOF_OP_FETCH 3'h5
`define SOF_FLUSH_SETTLE 3'h5
`define SOF_DW_LSB 3
`define SOF_BUF_RESET 1'h0
`endif

// file: src/sof_pkg.sv
// types shared by the ordering unit, the link checker and the bench; the memory end uses the map constants
package sof_pkg;
  typedef enum logic [2:0] {
    SOF_LOAD = 3'h0,
    SOF_STORE = 3'h1,
    SOF_FLUSH = 3'h2,
    SOF_ATOMIC = 3'h3,
    SOF_BARRIER = 3'h4,
    SOF_FETCH = 3'h5
  } sof_op_type;
endpackage : sof_pkg

// file: src/sof_mem_if.sv
// link between the processor-side ordering unit and the shared memory port
`timescale 1ns/100ps
interface sof_mem_if #(parameter int AW = 32, parameter int DW = 64);
  logic req_valid;
  logic req_ready;
  logic [2:0] req_op;
  logic [AW-1:0] req_addr;
  logic [DW-1:0] req_wdata;
  logic req_io;
  logic rsp_valid;
  logic [DW-1:0] rsp_rdata;
  modport cpu_end (output req_valid, req_op, req_addr, req_wdata, req_io, input req_ready, rsp_valid, rsp_rdata);
  modport mem_end (input req_valid, req_op, req_addr, req_wdata, req_io, output req_ready, rsp_valid, rsp_rdata);
endinterface : sof_mem_if

// file: src/sof_store_buf.sv
// store buffer: in total order drains oldest first; in partial order any entry
// not blocked by an older same-doubleword entry or an older barrier mark
`timescale 1ns/100ps
`include "sof_map.svh"
module sof_store_buf #(
  parameter int AW = 32,
  parameter int DW = 64,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // mode
  input wire logic partial_order_mode,
  // push side
  input wire logic push,
  input wire logic push_flush,
  input wire logic [AW-1:0] push_addr,
  input wire logic [DW-1:0] push_data,
  input wire logic barrier,
  // pop side
  input wire logic pop,
  output logic head_valid,
  output logic [$clog2(DEPTH)-1:0] head_idx,
  output logic head_flush,
  output logic [AW-1:0] head_addr,
  output logic [DW-1:0] head_data,
  // status
  output logic full,
  output logic empty,
  // load forwarding
  input wire logic [AW-1:0] fwd_addr,
  output logic fwd_hit,
  output logic [DW-1:0] fwd_data
);
  localparam int IW = $clog2(DEPTH);
  logic [DEPTH-1:0] valid_reg;
  logic [DEPTH-1:0] flush_reg;
  logic [IW-1:0] epoch_reg [DEPTH];
  logic [IW-1:0] cur_epoch_reg;
  logic dirty_reg;
  logic [AW-1:0] addr_reg [DEPTH];
  logic [DW-1:0] data_reg [DEPTH];
  logic [DEPTH-1:0] age_reg [DEPTH]; // age_reg[i][j]: j older than i
  logic [DEPTH-1:0] elig;
  logic [IW-1:0] free_idx;
  logic [DW-1:0] fwd_data_w;
  logic fwd_hit_w;
  logic [DEPTH-1:0] fwd_age;

  function automatic logic same_dw(input logic [AW-1:0] a, input logic [AW-1:0] b);
    return a[AW-1:`SOF_DW_LSB] == b[AW-1:`SOF_DW_LSB];
  endfunction : same_dw

  ////////////////////////////////////////////////////////////////////////////
  genvar gi, gj;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_elig
      logic [DEPTH-1:0] block;
      for (gj = 0; gj < DEPTH; gj++) begin : g_blk
        // total order blocks on any older entry; partial only on same location or older epoch
        assign block[gj] = valid_reg[gj] && age_reg[gi][gj] && (!partial_order_mode ||
          same_dw(addr_reg[gj], addr_reg[gi]) || epoch_reg[gj] != epoch_reg[gi]);
      end
      assign elig[gi] = valid_reg[gi] && (block == '0);
    end
  endgenerate

  always_comb begin
    head_valid = 1'b0;
    head_idx = '0;
    free_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (elig[i]) begin
        head_valid = 1'b1;
        head_idx = IW'(i);
      end
      if (!valid_reg[i]) free_idx = IW'(i);
    end
  end

  // youngest matching entry forwards its data so loads see own stores
  always_comb begin
    fwd_hit_w = 1'b0;
    fwd_data_w = '0;
    fwd_age = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (valid_reg[i] && !flush_reg[i] && same_dw(addr_reg[i], fwd_addr) && (!fwd_hit_w || (fwd_age & ~age_reg[i]) == '0)) begin
        fwd_hit_w = 1'b1;
        fwd_data_w = data_reg[i];
        fwd_age = age_reg[i] | (DEPTH'(1) << i);
      end
    end
  end

  assign head_flush = flush_reg[head_idx];
  assign head_addr = addr_reg[head_idx];
  assign head_data = data_reg[head_idx];
  assign full = &valid_reg;
  assign empty = ~|valid_reg;
  assign fwd_hit = fwd_hit_w;
  assign fwd_data = fwd_data_w;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg <= '0;
      flush_reg <= '0;
      cur_epoch_reg <= '0;
      dirty_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        epoch_reg[i] <= '0;
        addr_reg[i] <= '0;
        data_reg[i] <= '0;
        age_reg[i] <= '0;
      end
    end else begin
      // bump only after a push: at most DEPTH epochs stay live, so the narrow counter never aliases
      if (barrier && dirty_reg) cur_epoch_reg <= cur_epoch_reg + 1'b1;
      if (barrier) dirty_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        if (pop && head_idx == IW'(i)) valid_reg[i] <= 1'b0;
        age_reg[i] <= age_reg[i] & ~(pop ? (DEPTH'(1) << head_idx) : '0);
      end
      if (push && !full) begin
        valid_reg[free_idx] <= 1'b1;
        dirty_reg <= 1'b1;
        flush_reg[free_idx] <= push_flush;
        addr_reg[free_idx] <= push_addr;
        data_reg[free_idx] <= push_data;
        epoch_reg[free_idx] <= cur_epoch_reg;
        age_reg[free_idx] <= valid_reg & ~(pop ? (DEPTH'(1) << head_idx) : '0);
      end
    end
  end
endmodule : sof_store_buf

// file: src/sof_cpu_end.sv
// processor-side ordering unit: takes core operations and issues them to memory
`timescale 1ns/100ps
`include "sof_map.svh"
module sof_cpu_end #(
  parameter int AW = 32,
  parameter int DW = 64,
  parameter int DEPTH = 4,
  parameter bit HAS_PARTIAL = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // mode control
  input wire logic partial_order_req,
  output logic partial_order_mode,
  // core request
  input wire logic core_valid,
  output logic core_ready,
  input wire sof_pkg::sof_op_type core_op,
  input wire logic [AW-1:0] core_addr,
  input wire logic [DW-1:0] core_wdata,
  input wire logic core_io,
  input wire logic core_retire,
  // core answer
  output logic core_rsp_valid,
  output logic [DW-1:0] core_rsp_data,
  output logic fetch_safe,
  // memory side
  sof_mem_if.cpu_end mem
);
  typedef enum logic [2:0] {SOF_IDLE, SOF_DRAIN, SOF_ISSUE, SOF_WAIT, SOF_ATOM_ST} sof_state_type;
  sof_state_type state_reg, state_next;
  logic mode_reg;
  logic [2:0] op_reg;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] wdata_reg;
  logic io_reg;
  logic req_valid_reg, req_valid_next;
  logic [2:0] req_op_reg, req_op_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic [DW-1:0] rsp_data_reg, rsp_data_next;
  logic [2:0] settle_reg;
  logic fetch_safe_reg;
  logic buf_head_valid, buf_head_flush, buf_full, buf_empty, buf_fwd_hit;
  logic [$clog2(DEPTH)-1:0] buf_head_idx;
  logic [AW-1:0] buf_head_addr;
  logic [DW-1:0] buf_head_data, buf_fwd_data;
  logic take_op;
  logic is_store_like;
  logic buf_push;
  logic buf_pop;
  logic buf_issue;
  logic needs_drain;

  ////////////////////////////////////////////////////////////////////////////
  // core side: non-io stores and flushes enter the buffer, barriers bump its epoch; others go through the engine
  assign is_store_like = (core_op == sof_pkg::SOF_STORE || core_op == sof_pkg::SOF_FLUSH) && !core_io;
  // io accesses, atomics and fetches wait for an empty buffer so nothing overtakes
  assign needs_drain = core_io || core_op == sof_pkg::SOF_ATOMIC || core_op == sof_pkg::SOF_FETCH;
  assign take_op = core_valid && core_ready;
  assign buf_push = take_op && is_store_like;
  assign core_ready = state_reg == SOF_IDLE && !rsp_valid_reg &&
    (is_store_like ? !buf_full : (!needs_drain || buf_empty)) && !(req_valid_reg);
  assign buf_issue = state_reg == SOF_IDLE && !req_valid_reg && buf_head_valid && !take_op;
  assign buf_pop = req_valid_reg && mem.req_ready && req_op_reg != `SOF_OP_LOAD &&
    req_op_reg != `SOF_OP_ATOMIC && req_op_reg != `SOF_OP_FETCH && state_reg == SOF_DRAIN;

  sof_store_buf #(.AW(AW), .DW(DW), .DEPTH(DEPTH)) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .partial_order_mode(mode_reg),
    .push(buf_push),
    .push_flush(core_op == sof_pkg::SOF_FLUSH),
    .push_addr(core_addr),
    .push_data(core_wdata),
    .barrier(take_op && core_op == sof_pkg::SOF_BARRIER),
    .pop(buf_pop),
    .head_valid(buf_head_valid),
    .head_idx(buf_head_idx),
    .head_flush(buf_head_flush),
    .head_addr(buf_head_addr),
    .head_data(buf_head_data),
    .full(buf_full),
    .empty(buf_empty),
    .fwd_addr(core_addr),
    .fwd_hit(buf_fwd_hit),
    .fwd_data(buf_fwd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    req_valid_next = req_valid_reg;
    req_op_next = req_op_reg;
    rsp_valid_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    unique case (state_reg)
      SOF_IDLE: begin
        if (take_op && core_op == sof_pkg::SOF_LOAD && !core_io && buf_fwd_hit) begin
          rsp_valid_next = 1'b1;
          rsp_data_next = buf_fwd_data;
        end else if (take_op && core_op == sof_pkg::SOF_BARRIER) begin
          rsp_valid_next = 1'b1;
        end else if (take_op && !is_store_like) begin
          req_valid_next = 1'b1;
          req_op_next = (core_op == sof_pkg::SOF_ATOMIC) ? `SOF_OP_LOAD : 3'(core_op);
          state_next = SOF_ISSUE;
        end else if (buf_issue) begin
          req_valid_next = 1'b1;
          req_op_next = buf_head_flush ? `SOF_OP_FLUSH : `SOF_OP_STORE;
          state_next = SOF_DRAIN;
        end
      end
      SOF_DRAIN: begin
        if (mem.req_ready) begin
          req_valid_next = 1'b0;
          state_next = SOF_IDLE;
        end
      end
      SOF_ISSUE: begin
        if (mem.req_ready) begin
          req_valid_next = 1'b0;
          state_next = (req_op_reg == `SOF_OP_STORE || req_op_reg == `SOF_OP_FLUSH) ? SOF_IDLE : SOF_WAIT;
          rsp_valid_next = req_op_reg == `SOF_OP_STORE || req_op_reg == `SOF_OP_FLUSH;
        end
      end
      SOF_WAIT: begin
        if (mem.rsp_valid) begin
          rsp_data_next = mem.rsp_rdata;
          if (op_reg == `SOF_OP_ATOMIC) begin
            req_valid_next = 1'b1;
            req_op_next = `SOF_OP_STORE;
            state_next = SOF_ATOM_ST;
          end else begin
            rsp_valid_next = 1'b1;
            state_next = SOF_IDLE;
          end
        end
      end
      SOF_ATOM_ST: begin
        if (mem.req_ready) begin
          req_valid_next = 1'b0;
          rsp_valid_next = 1'b1;
          state_next = SOF_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SOF_IDLE;
      mode_reg <= 1'b0;
      op_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      io_reg <= 1'b0;
      req_valid_reg <= 1'b0;
      req_op_reg <= '0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
      settle_reg <= '0;
      fetch_safe_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      req_valid_reg <= req_valid_next;
      req_op_reg <= req_op_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg <= rsp_data_next;
      // mode changes only while quiet so fenced programs see no difference
      if (state_reg == SOF_IDLE && buf_empty && !req_valid_reg) begin
        mode_reg <= HAS_PARTIAL && partial_order_req;
      end
      if (take_op && !is_store_like) begin
        op_reg <= 3'(core_op);
        addr_reg <= core_addr;
        wdata_reg <= core_wdata;
        io_reg <= core_io;
      end else if (buf_issue) begin
        op_reg <= buf_head_flush ? `SOF_OP_FLUSH : `SOF_OP_STORE;
        addr_reg <= buf_head_addr;
        wdata_reg <= buf_head_data;
        io_reg <= 1'b0;
      end
      // own fetches of a flushed location wait out five retired instructions
      if (buf_push && core_op == sof_pkg::SOF_FLUSH) begin
        settle_reg <= `SOF_FLUSH_SETTLE;
        fetch_safe_reg <= 1'b0;
      end else if (!buf_empty && settle_reg == 3'h0) begin
        fetch_safe_reg <= 1'b0;
      end else if (settle_reg != 3'h0) begin
        if (core_retire) settle_reg <= settle_reg - 3'h1;
      end else begin
        fetch_safe_reg <= buf_empty;
      end
    end
  end

  assign partial_order_mode = mode_reg;
  assign core_rsp_valid = rsp_valid_reg;
  assign core_rsp_data = rsp_data_reg;
  assign fetch_safe = fetch_safe_reg;
  assign mem.req_valid = req_valid_reg;
  assign mem.req_op = req_op_reg;
  assign mem.req_addr = addr_reg;
  assign mem.req_wdata = wdata_reg;
  assign mem.req_io = io_reg;
endmodule : sof_cpu_end

// file: src/sof_mem_end.sv
// shared memory end: serialises all requests and locks non-io atomics across their two halves
`timescale 1ns/100ps
`include "sof_map.svh"
module sof_mem_end #(
  parameter int AW = 32,
  parameter int DW = 64
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // processor link
  sof_mem_if.mem_end mem,
  // backing store
  output logic store_we,
  output logic store_flush,
  output logic [AW-1:0] store_addr,
  output logic [DW-1:0] store_wdata,
  input wire logic [DW-1:0] store_rdata,
  // arbitration
  input wire logic other_busy,
  output logic atomic_lock
);
  logic we_reg, flush_reg, rsp_valid_reg, lock_reg;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] wdata_reg;
  logic accept;
  logic is_read;
  // stalls other masters while a non-io atomic pair is open; holds off this link while other_busy is set and no lock is held
  assign mem.req_ready = !other_busy || lock_reg;
  assign accept = mem.req_valid && mem.req_ready && !rsp_valid_reg;
  assign is_read = mem.req_op == `SOF_OP_LOAD || mem.req_op == `SOF_OP_FETCH;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      we_reg <= 1'b0;
      flush_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      lock_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      we_reg <= accept && mem.req_op == `SOF_OP_STORE;
      flush_reg <= accept && mem.req_op == `SOF_OP_FLUSH;
      rsp_valid_reg <= accept && is_read;
      if (accept) begin
        addr_reg <= mem.req_addr;
        wdata_reg <= mem.req_wdata;
      end
      // any non-io load holds the lock until the next accepted request, the paired store for an atomic
      if (accept && mem.req_op == `SOF_OP_LOAD && !mem.req_io) lock_reg <= 1'b1;
      else if (accept) lock_reg <= 1'b0;
    end
  end

  assign store_we = we_reg;
  assign store_flush = flush_reg;
  assign store_addr = addr_reg;
  assign store_wdata = wdata_reg;
  assign mem.rsp_valid = rsp_valid_reg;
  // the store is read on the address latched at accept, so data lines up with the answer pulse
  assign mem.rsp_rdata = store_rdata;
  assign atomic_lock = lock_reg;
endmodule : sof_mem_end

// file: bench/sof_link_checker.sv
// concurrent checks on the link between the ordering unit and the memory end
`timescale 1ns/100ps
module sof_link_checker #(
  parameter int AW = 32,
  parameter int DW = 64
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic req_io,
  // answer
  input wire logic rsp_valid,
  input wire logic [DW-1:0] rsp_rdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  wire acc = req_valid && req_ready;
  wire rd_acc = acc && (req_op == sof_pkg::SOF_LOAD || req_op == sof_pkg::SOF_FETCH);
  ////////////////////////////////////////////////////////////////
  req_hold_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req_op) && $stable(req_addr)
    && $stable(req_wdata) && $stable(req_io)) else $error("request changed before accept");
  read_answer_a: assert property (rd_acc |=> rsp_valid) else $error("read not answered next cycle");
  load_blocks_a: assert property (rd_acc |=> !req_valid) else $error("request issued behind open load");
  rsp_cause_a: assert property (rsp_valid |-> $past(acc)) else $error("answer without accepted request");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("answer longer than one cycle");
  io_order_a: assert property (acc && req_io |=> !req_valid) else $error("io access overlapped");
  op_legal_a: assert property (req_valid |-> req_op inside {sof_pkg::SOF_LOAD, sof_pkg::SOF_STORE,
    sof_pkg::SOF_FLUSH, sof_pkg::SOF_FETCH}) else $error("illegal op on link");
  req_done_a: assert property ($rose(req_valid) |-> ##[0:200] req_ready) else $error("request never accepted");
  ////////////////////////////////////////////////////////////////
  fetch_seen_c: cover property (rd_acc && req_op == sof_pkg::SOF_FETCH);
  flush_seen_c: cover property (acc && req_op == sof_pkg::SOF_FLUSH);
  io_seen_c: cover property (acc && req_io);
  data_seen_c: cover property (rsp_valid && rsp_rdata != '0);
endmodule : sof_link_checker

// file: bench/store_order_flush_sync_tb.sv
// self-checking bench joining the ordering unit and the memory end
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module store_order_flush_sync_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic partial_order_req = 1'b0;
  logic partial_order_mode;
  logic core_valid = 1'b0;
  logic core_ready;
  sof_pkg::sof_op_type core_op = sof_pkg::SOF_LOAD;
  logic [31:0] core_addr = 32'h0;
  logic [63:0] core_wdata = 64'h0;
  logic core_io = 1'b0;
  logic core_retire = 1'b0;
  logic core_rsp_valid;
  logic [63:0] core_rsp_data;
  logic fetch_safe;
  logic store_we;
  logic store_flush;
  logic atomic_lock;
  logic [31:0] store_addr;
  logic [63:0] store_wdata;
  logic [63:0] store_rdata;
  logic other_busy = 1'b0;
  logic [63:0] mem_arr [16];
  logic [63:0] exp_arr [16];
  logic [31:0] wlog [$];
  logic [63:0] got;
  int flush_seen = 0;
  logic [3:0] idx;
  int fail_count = 0;
  int comparisons = 0;
  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  sof_mem_if mem_if ();
  sof_cpu_end #(.DEPTH(4), .HAS_PARTIAL(1'b1)) i_sof_cpu_end (
    .core_clk(core_clk), .rst_n(rst_n), .partial_order_req(partial_order_req),
    .partial_order_mode(partial_order_mode), .core_valid(core_valid), .core_ready(core_ready),
    .core_op(core_op), .core_addr(core_addr), .core_wdata(core_wdata), .core_io(core_io),
    .core_retire(core_retire), .core_rsp_valid(core_rsp_valid), .core_rsp_data(core_rsp_data),
    .fetch_safe(fetch_safe), .mem(mem_if));
  sof_mem_end i_sof_mem_end (
    .core_clk(core_clk), .rst_n(rst_n), .mem(mem_if), .store_we(store_we), .store_flush(store_flush),
    .store_addr(store_addr), .store_wdata(store_wdata), .store_rdata(store_rdata),
    .other_busy(other_busy), .atomic_lock(atomic_lock));
  sof_link_checker i_sof_link_checker (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(mem_if.req_valid), .req_ready(mem_if.req_ready),
    .req_op(mem_if.req_op), .req_addr(mem_if.req_addr), .req_wdata(mem_if.req_wdata),
    .req_io(mem_if.req_io), .rsp_valid(mem_if.rsp_valid), .rsp_rdata(mem_if.rsp_rdata));
  ////////////////////////////////////////////////////////////////
  // backing store; the other master steals about a quarter of the cycles
  assign store_rdata = mem_arr[store_addr[6:3]];
  always @(posedge core_clk) begin
    other_busy <= ($urandom_range(3) == 0);
    if (store_flush === 1'b1) flush_seen++;
    if (store_we === 1'b1) begin
      mem_arr[store_addr[6:3]] <= store_wdata;
      wlog.push_back(store_addr);
    end
  end
  ////////////////////////////////////////////////////////////////
  // ready is sampled at the falling edge, where it already shows its value for the next rising edge
  task automatic issue(input sof_pkg::sof_op_type op, input logic [3:0] ix, input logic [63:0] d, input logic io);
    bit tk;
    tk = 1'b0;
    @(posedge core_clk);
    core_valid <= 1'b1;
    core_op <= op;
    core_addr <= {25'h0, ix, 3'h0};
    core_wdata <= d;
    core_io <= io;
    for (int n = 0; n < 300 && !tk; n++) begin
      @(negedge core_clk);
      tk = (core_ready === 1'b1);
      @(posedge core_clk);
    end
    core_valid <= 1'b0;
    if (op == sof_pkg::SOF_STORE) exp_arr[ix] = d;
    `CHK("core ready", 1'b1, tk)
  endtask : issue
  task automatic await_rsp(output logic [63:0] d);
    d = 64'hx;
    for (int n = 0; n < 300; n++) begin
      @(negedge core_clk);
      if (core_rsp_valid === 1'b1) begin
        d = core_rsp_data;
        break;
      end
    end
  endtask : await_rsp
  task automatic rd(input sof_pkg::sof_op_type op, input logic [3:0] ix, input logic io, input string nm);
    issue(op, ix, 64'h0, io);
    await_rsp(got);
    `CHK(nm, exp_arr[ix], got)
  endtask : rd
  task automatic set_mode(input logic m);
    @(posedge core_clk);
    partial_order_req <= m;
    for (int n = 0; n < 50 && partial_order_mode !== m; n++) @(negedge core_clk);
    `CHK("mode", m, partial_order_mode)
  endtask : set_mode
  task automatic retire(input int n);
    repeat (n) begin
      @(posedge core_clk);
      core_retire <= 1'b1;
      @(posedge core_clk);
      core_retire <= 1'b0;
    end
    repeat (2) @(negedge core_clk);
  endtask : retire
  task conclude;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hecba));
    for (int i = 0; i < 16; i++) begin
      mem_arr[i] = 64'h0;
      exp_arr[i] = 64'h0;
    end
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // a fresh random program in each mode must give the expected results
    for (int m = 0; m < 2; m++) begin
      set_mode(m[0]);
      for (int k = 0; k < 60; k++) begin
        idx = 4'($urandom_range(7));
        if ($urandom_range(1) == 1) issue(sof_pkg::SOF_STORE, idx, {$urandom, $urandom}, 1'b0);
        else rd(sof_pkg::SOF_LOAD, idx, 1'b0, "load");
      end
      issue(sof_pkg::SOF_STORE, 4'h3, 64'hc0de, 1'b0);
      issue(sof_pkg::SOF_STORE, 4'h3, 64'hbeef, 1'b0);
      rd(sof_pkg::SOF_LOAD, 4'h3, 1'b0, "fwd load");
      repeat (100) @(posedge core_clk);
      for (int i = 0; i < 8; i++) `CHK("mem final", exp_arr[i], mem_arr[i])
      $display("test random mode %0d done", m);
    end
    // two stores across a barrier must land in program order
    wlog.delete();
    issue(sof_pkg::SOF_STORE, 4'h9, 64'h1, 1'b0);
    issue(sof_pkg::SOF_BARRIER, 4'h0, 64'h0, 1'b0);
    await_rsp(got);
    issue(sof_pkg::SOF_STORE, 4'ha, 64'h2, 1'b0);
    repeat (100) @(posedge core_clk);
    `CHK("barrier size", 2, wlog.size())
    `CHK("barrier first", 32'h48, wlog[0])
    `CHK("barrier second", 32'h50, wlog[1])
    $display("test barrier done");
    // io store then io load of the same place
    issue(sof_pkg::SOF_STORE, 4'hb, 64'h5a5a, 1'b1);
    await_rsp(got);
    exp_arr[11] = 64'h5a5a;
    rd(sof_pkg::SOF_LOAD, 4'hb, 1'b1, "io load");
    $display("test io done");
    // atomic returns the old value and leaves the new one
    issue(sof_pkg::SOF_ATOMIC, 4'h4, 64'hab, 1'b0);
    await_rsp(got);
    `CHK("atomic old", exp_arr[4], got)
    exp_arr[4] = 64'hab;
    repeat (4) @(negedge core_clk);
    `CHK("lock released", 1'b0, atomic_lock)
    rd(sof_pkg::SOF_LOAD, 4'h4, 1'b0, "atomic new");
    $display("test atomic done");
    // own fetch is safe only after five retired instructions
    issue(sof_pkg::SOF_STORE, 4'h6, 64'h77, 1'b0);
    issue(sof_pkg::SOF_FLUSH, 4'h6, 64'h0, 1'b0);
    retire(4);
    `CHK("not settled", 1'b0, fetch_safe)
    retire(1);
    `CHK("settled", 1'b1, fetch_safe)
    rd(sof_pkg::SOF_FETCH, 4'h6, 1'b0, "fetch flushed");
    rd(sof_pkg::SOF_FETCH, 4'h4, 1'b0, "fetch next");
    `CHK("flush reached memory", 1, flush_seen)
    $display("test flush done");
    conclude();
  end
  initial begin
    #200000;
    `CHK("watchdog", 1'b0, 1'b1)
    conclude();
  end
endmodule : store_order_flush_sync_tb
